// *** src/ppst_pkg.sv ***
// Purpose: shared constants and types of the port sequence timing block
// Assumes: 50 MHz pclk; all times below in their own unit
// Notes: register offsets are byte addresses on a 32-bit APB
package ppst_pkg;
	localparam int NPORT = 4;
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int RSTPIN_MIN_US = 300;
	localparam int RSTPIN_CYC = (CLK_HZ / 1_000_000) * RSTPIN_MIN_US;
	// ms figures, counted on the 1 ms tick
	localparam int DET_RESET_MS = 80;
	localparam int DET_PHASE_MS = 100;
	localparam int DET_MAX_MS = 330;
	localparam int MIDSPAN_DLY_MS = 2200;
	localparam int CADENCE_MS = 2200;
	localparam int CLASS_MS = 19;
	localparam int START_MS = 60;
	localparam int FAULT_MS = 60;
	localparam int UVLO_DLY_MS = 3;
	localparam int WDOG_MS = 164;
	localparam logic [8:0] DISC_RST = 9'h15E;
	localparam logic [2:0] ACTH_RST = 3'h0;
	localparam int TMR_W = 13;
	// analog decision figures
	localparam logic [15:0] OPEN_DUA = 16'h007D;
	localparam int RLO_NUM = 152;
	localparam int RLO_DEN = 100;
	localparam int RHI_NUM = 32;
	localparam int RHI_DEN = 10;
	localparam logic [9:0] DCTH_MV = 10'h004;
	localparam logic [9:0] ADC_FULL = 10'h1FF;
	localparam int RST16 = 16;
	localparam int RST32 = 32;
	localparam int RST64 = 64;
	// register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DISC = 8'h04;
	localparam logic [7:0] ADDR_ACTH = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0C;
	localparam logic [7:0] ADDR_FAULT = 8'h10;
	localparam logic [7:0] ADDR_CUR_LO = 8'h14;
	localparam logic [7:0] ADDR_CUR_HI = 8'h18;
	localparam logic [7:0] ADDR_WDOG = 8'h1C;
	localparam logic [7:0] ADDR_GRST = 8'h20;
	localparam int GRST_SOFT_BIT = 4;

	typedef struct packed {
		logic midspan;
		logic [1:0] restart_delay_select;
		logic restart_delay_enable;
		logic [3:0] ac_disconnect_enable;
		logic [3:0] dc_disconnect_enable;
		logic [3:0] port_enable;
	} ppst_ctrl_t;

	typedef struct packed {
		logic [13:0] volt_mv;
		logic [15:0] cur_dua;
		logic [9:0] sense_mv;
	} ppst_meas_t;

	typedef enum logic [3:0] {ST_OFF, ST_MIDDLY, ST_DRST, ST_PH1, ST_PH2, ST_CADENCE,
		ST_CLASS, ST_START, ST_ON, ST_RESTART} ppst_state_t;
	typedef enum logic [2:0] {DET_NONE, DET_OK, DET_SHORT, DET_OPEN, DET_BADR} ppst_det_t;
	typedef enum logic [1:0] {PROBE_OFF, PROBE_4V, PROBE_9V, PROBE_CLASS} ppst_probe_t;
endpackage

// *** src/ppst_top.sv ***
// Purpose: four-port detect, classify, power and disconnect sequencer with APB registers
// Assumes: measurements come from an ADC on pclk; comparator and strap pins are async
// Notes: one 1 ms tick drives every port timer, so each wait may be up to 1 ms short
// How it works
// - dc disconnect: gate off after low sense current for the hold time
// - the disconnect hold time is a software writable register
// - ac enabled port powers off on low probe current; 3-bit threshold field
// - ac enabled port is not powered past startup while the oscillator fail flag is set
// - detection probes first at 4 V, then at 9.3 V
// - after phase one, port near the positive rail reports a short
// - phase-one probe current below 12.5 uA reports an open port
// - signature resistance is voltage step over current step between phases
// - signatures below 15.2 kohm or above 32 kohm are rejected
// - port voltage gets its reset time before detection starts
// - midspan mode waits 2.0 to 2.4 s before detection
// - classification lasts at most 23 ms
// - startup current limit allowed for 60 ms after gate on
// - overcurrent after startup tolerated at most 70 ms, then a fault
// - restart wait after overcurrent: 16, 32, 64 fault times or none
// - operation starts 2 to 4 ms after supply lockout clears
// - watchdog counter decrements every 164 ms
// - reset pin held low 300 us returns all registers to defaults
// - address, auto and midspan straps latch on reset release
// - midspan strap low selects endpoint, high selects midspan
// - open-drain interrupt low while any fault stands, released on clear
// - midspan failed detection waits 2 to 2.4 s before retry
// - writing one to bit 4 of the global reset register resets all
//
// Chosen here: register access over APB and the address map.
module ppst_top #(
	parameter int TICK_CYC = ppst_pkg::TICK_CYC,
	parameter int RSTPIN_CYC = ppst_pkg::RSTPIN_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reset_pin_n,
	input wire logic [3:0] address_straps,
	input wire logic auto_strap,
	input wire logic midspan_strap,
	input wire logic uvlo_ok,
	input wire logic osc_fail,
	input wire logic [3:0] ac_below,
	input wire logic [3:0] near_rail,
	input wire logic [3:0] overcurrent,
	input wire ppst_pkg::ppst_meas_t [3:0] meas,
	output logic [3:0] gate_on,
	output ppst_pkg::ppst_probe_t [3:0] probe_output,
	output logic [2:0] ac_threshold_sel,
	output logic [3:0] address_latched,
	output logic int_o,
	output logic int_oe
);
	localparam int SW = 21;
	localparam int RCW = $clog2(RSTPIN_CYC + 1);
	localparam int PCW = $clog2(TICK_CYC + 1);

	// ****************************************
	// synchronisers and reset sources
	// ****************************************
	logic [SW-1:0] sync1_ff;
	logic [SW-1:0] sync2_ff;
	logic rpin_s, auto_s, mid_s, uvlo_s, oscf_s;
	logic [3:0] addr_s, acb_s, rail_s, oc_s;
	logic [RCW-1:0] rcnt_ff;
	logic pin_hold_ff, soft_rst_ff, clr, pin_rise;
	logic [2:0] ld_ff;
	logic load;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else if (ce) begin
			sync1_ff <= {reset_pin_n, auto_strap, midspan_strap, address_straps, uvlo_ok,
				osc_fail, ac_below, near_rail, overcurrent};
			sync2_ff <= sync1_ff;
		end
	end
	assign {rpin_s, auto_s, mid_s, addr_s, uvlo_s, oscf_s, acb_s, rail_s, oc_s} = sync2_ff;

	// short glitches on the pin are ignored; only a qualified low clears state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcnt_ff <= '0;
			pin_hold_ff <= 1'b0;
		end else if (ce) begin
			if (rpin_s) begin
				rcnt_ff <= '0;
				pin_hold_ff <= 1'b0;
			end else if (rcnt_ff == RCW'(RSTPIN_CYC - 1)) begin
				pin_hold_ff <= 1'b1;
			end else begin
				rcnt_ff <= rcnt_ff + 1'b1;
			end
		end
	end
	assign pin_rise = pin_hold_ff & rpin_s;
	assign clr = pin_hold_ff | soft_rst_ff;

	// straps sampled three edges after release so the synchroniser has settled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ld_ff <= 3'h7;
		end else if (ce) begin
			ld_ff <= {ld_ff[1:0], pin_rise | soft_rst_ff};
		end
	end
	assign load = ld_ff[2];

	// ****************************************
	// time base, supply delay, watchdog
	// ****************************************
	logic [PCW-1:0] pre_ff;
	logic tick_ff;
	logic [2:0] uvcnt_ff;
	logic ready_ff;
	logic [7:0] wd_ff;
	logic [7:0] wdpre_ff;
	logic wd_evt_ff;
	logic wr, setup;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= '0;
			tick_ff <= 1'b0;
		end else if (ce) begin
			tick_ff <= (pre_ff == PCW'(TICK_CYC - 1));
			pre_ff <= (pre_ff == PCW'(TICK_CYC - 1)) ? '0 : pre_ff + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uvcnt_ff <= '0;
			ready_ff <= 1'b0;
		end else if (ce) begin
			if (!uvlo_s) begin
				uvcnt_ff <= '0;
				ready_ff <= 1'b0;
			end else if (tick_ff && !ready_ff) begin
				uvcnt_ff <= uvcnt_ff + 1'b1;
				ready_ff <= (uvcnt_ff == 3'(ppst_pkg::UVLO_DLY_MS - 1));
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_ff <= '0;
			wdpre_ff <= '0;
			wd_evt_ff <= 1'b0;
		end else if (ce) begin
			wd_evt_ff <= 1'b0;
			if (clr) begin
				wd_ff <= '0;
				wdpre_ff <= '0;
			end else if (wr && paddr == ppst_pkg::ADDR_WDOG) begin
				wd_ff <= pwdata[7:0];
				wdpre_ff <= '0;
			end else if (tick_ff) begin
				if (wdpre_ff == 8'(ppst_pkg::WDOG_MS - 1)) begin
					wdpre_ff <= '0;
					if (wd_ff != 8'h00) begin
						wd_ff <= wd_ff - 1'b1;
						wd_evt_ff <= (wd_ff == 8'h01);
					end
				end else begin
					wdpre_ff <= wdpre_ff + 1'b1;
				end
			end
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	ppst_pkg::ppst_ctrl_t ctrl_ff;
	logic [8:0] disc_ff;
	logic [2:0] acth_ff;
	logic auto_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= '0;
			disc_ff <= ppst_pkg::DISC_RST;
			acth_ff <= ppst_pkg::ACTH_RST;
			auto_ff <= 1'b0;
			address_latched <= '0;
		end else if (ce) begin
			if (clr) begin
				ctrl_ff <= '0;
				disc_ff <= ppst_pkg::DISC_RST;
				acth_ff <= ppst_pkg::ACTH_RST;
			end else if (load) begin
				ctrl_ff.port_enable <= {4{auto_s}};
				ctrl_ff.midspan <= mid_s;
				auto_ff <= auto_s;
				address_latched <= addr_s;
			end else if (wr) begin
				if (paddr == ppst_pkg::ADDR_CTRL) begin
					ctrl_ff <= pwdata[15:0];
				end
				if (paddr == ppst_pkg::ADDR_DISC) begin
					disc_ff <= pwdata[8:0];
				end
				if (paddr == ppst_pkg::ADDR_ACTH) begin
					acth_ff <= pwdata[2:0];
				end
			end
		end
	end
	assign ac_threshold_sel = acth_ff;

	// ****************************************
	// port sequencers
	// ****************************************
	ppst_pkg::ppst_state_t st_ff [4];
	ppst_pkg::ppst_state_t nxt_st [4];
	ppst_pkg::ppst_det_t det_ff [4];
	ppst_pkg::ppst_det_t nxt_det [4];
	logic [ppst_pkg::TMR_W-1:0] tmr_ff [4];
	logic [8:0] dct_ff [4];
	logic [6:0] oct_ff [4];
	logic [13:0] v1_ff [4];
	logic [15:0] i1_ff [4];
	logic [8:0] cur_ff [4];
	logic [3:0] oc_evt, dis_evt, cap;
	logic [3:0] oc_evt_ff, dis_evt_ff;

	function automatic logic tmr_go(input logic [ppst_pkg::TMR_W-1:0] t, input int ms);
		tmr_go = (int'(t) + 1) >= ms;
	endfunction

	function automatic logic sig_ok(input logic [13:0] v1, input logic [13:0] v2,
		input logic [15:0] i1, input logic [15:0] i2);
		int dv;
		int di;
		dv = int'(v2) - int'(v1);
		di = int'(i2) - int'(i1);
		sig_ok = (di > 0) && (dv > 0)
			&& (ppst_pkg::RLO_DEN * dv >= ppst_pkg::RLO_NUM * di)
			&& (ppst_pkg::RHI_DEN * dv <= ppst_pkg::RHI_NUM * di);
	endfunction

	function automatic int restart_ms(input logic [1:0] sel);
		case (sel)
			2'h0: restart_ms = ppst_pkg::RST16 * ppst_pkg::FAULT_MS;
			2'h1: restart_ms = ppst_pkg::RST32 * ppst_pkg::FAULT_MS;
			2'h2: restart_ms = ppst_pkg::RST64 * ppst_pkg::FAULT_MS;
			default: restart_ms = 0;
		endcase
	endfunction

	always_comb begin
		for (int p = 0; p < ppst_pkg::NPORT; p++) begin
			nxt_st[p] = st_ff[p];
			nxt_det[p] = det_ff[p];
			oc_evt[p] = 1'b0;
			dis_evt[p] = 1'b0;
			cap[p] = 1'b0;
			case (st_ff[p])
				ppst_pkg::ST_OFF: begin
					nxt_st[p] = ctrl_ff.midspan ? ppst_pkg::ST_MIDDLY : ppst_pkg::ST_DRST;
				end
				ppst_pkg::ST_MIDDLY: begin
					if (tick_ff && tmr_go(tmr_ff[p], ppst_pkg::MIDSPAN_DLY_MS)) begin
						nxt_st[p] = ppst_pkg::ST_DRST;
					end
				end
				ppst_pkg::ST_DRST: begin
					if (tick_ff && tmr_go(tmr_ff[p], ppst_pkg::DET_RESET_MS)) begin
						nxt_st[p] = ppst_pkg::ST_PH1;
					end
				end
				ppst_pkg::ST_PH1: begin
					if (tick_ff && tmr_go(tmr_ff[p], ppst_pkg::DET_PHASE_MS)) begin
						cap[p] = 1'b1;
						if (rail_s[p]) begin
							nxt_det[p] = ppst_pkg::DET_SHORT;
						end else if (meas[p].cur_dua < ppst_pkg::OPEN_DUA) begin
							nxt_det[p] = ppst_pkg::DET_OPEN;
						end
						nxt_st[p] = (rail_s[p] || meas[p].cur_dua < ppst_pkg::OPEN_DUA)
							? (ctrl_ff.midspan ? ppst_pkg::ST_CADENCE : ppst_pkg::ST_DRST)
							: ppst_pkg::ST_PH2;
					end
				end
				ppst_pkg::ST_PH2: begin
					// reset plus two phases stays inside the 330 ms detection budget
					if (tick_ff && tmr_go(tmr_ff[p], ppst_pkg::DET_PHASE_MS)) begin
						if (sig_ok(v1_ff[p], meas[p].volt_mv, i1_ff[p], meas[p].cur_dua)) begin
							nxt_det[p] = ppst_pkg::DET_OK;
							nxt_st[p] = ppst_pkg::ST_CLASS;
						end else begin
							nxt_det[p] = ppst_pkg::DET_BADR;
							nxt_st[p] = ctrl_ff.midspan ? ppst_pkg::ST_CADENCE : ppst_pkg::ST_DRST;
						end
					end
				end
				ppst_pkg::ST_CADENCE: begin
					if (tick_ff && tmr_go(tmr_ff[p], ppst_pkg::CADENCE_MS)) begin
						nxt_st[p] = ppst_pkg::ST_DRST;
					end
				end
				ppst_pkg::ST_CLASS: begin
					// a port blocked by oscillator fail drops back and redetects, so the
					// probe never stays at class level past the class time
					if (tick_ff && tmr_go(tmr_ff[p], ppst_pkg::CLASS_MS)) begin
						nxt_st[p] = (ctrl_ff.ac_disconnect_enable[p] && oscf_s) ? ppst_pkg::ST_OFF
							: ppst_pkg::ST_START;
					end
				end
				ppst_pkg::ST_START: begin
					if (tick_ff && tmr_go(tmr_ff[p], ppst_pkg::START_MS)) begin
						nxt_st[p] = ppst_pkg::ST_ON;
					end
				end
				ppst_pkg::ST_ON: begin
					if (oc_s[p] && tick_ff && (int'(oct_ff[p]) + 1 >= ppst_pkg::FAULT_MS)) begin
						oc_evt[p] = 1'b1;
						nxt_st[p] = ctrl_ff.restart_delay_enable ? ppst_pkg::ST_RESTART
							: ppst_pkg::ST_OFF;
					end else if (ctrl_ff.dc_disconnect_enable[p]
						&& meas[p].sense_mv < ppst_pkg::DCTH_MV && tick_ff
						&& (int'(dct_ff[p]) + 1 >= int'(disc_ff))) begin
						dis_evt[p] = 1'b1;
						nxt_st[p] = ppst_pkg::ST_OFF;
					end else if (ctrl_ff.ac_disconnect_enable[p] && (acb_s[p] || oscf_s)) begin
						dis_evt[p] = 1'b1;
						nxt_st[p] = ppst_pkg::ST_OFF;
					end
				end
				ppst_pkg::ST_RESTART: begin
					if (ctrl_ff.restart_delay_select == 2'h3 ||
						(tick_ff && tmr_go(tmr_ff[p], restart_ms(ctrl_ff.restart_delay_select)))) begin
						nxt_st[p] = ppst_pkg::ST_OFF;
					end
				end
				default: nxt_st[p] = ppst_pkg::ST_OFF;
			endcase
			if (!ctrl_ff.port_enable[p] || !ready_ff) begin
				nxt_st[p] = ppst_pkg::ST_OFF;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < ppst_pkg::NPORT; p++) begin
				st_ff[p] <= ppst_pkg::ST_OFF;
				det_ff[p] <= ppst_pkg::DET_NONE;
				tmr_ff[p] <= '0;
				dct_ff[p] <= '0;
				oct_ff[p] <= '0;
				v1_ff[p] <= '0;
				i1_ff[p] <= '0;
			end
			oc_evt_ff <= '0;
			dis_evt_ff <= '0;
		end else if (ce) begin
			oc_evt_ff <= clr ? 4'h0 : oc_evt;
			dis_evt_ff <= clr ? 4'h0 : dis_evt;
			for (int p = 0; p < ppst_pkg::NPORT; p++) begin
				st_ff[p] <= clr ? ppst_pkg::ST_OFF : nxt_st[p];
				det_ff[p] <= clr ? ppst_pkg::DET_NONE : nxt_det[p];
				if (clr || nxt_st[p] != st_ff[p]) begin
					tmr_ff[p] <= '0;
				end else if (tick_ff && tmr_ff[p] != '1) begin
					tmr_ff[p] <= tmr_ff[p] + 1'b1;
				end
				if (st_ff[p] != ppst_pkg::ST_ON || meas[p].sense_mv >= ppst_pkg::DCTH_MV) begin
					dct_ff[p] <= '0;
				end else if (tick_ff && dct_ff[p] != '1) begin
					dct_ff[p] <= dct_ff[p] + 1'b1;
				end
				if (st_ff[p] != ppst_pkg::ST_ON || !oc_s[p]) begin
					oct_ff[p] <= '0;
				end else if (tick_ff && oct_ff[p] != '1) begin
					oct_ff[p] <= oct_ff[p] + 1'b1;
				end
				if (cap[p]) begin
					v1_ff[p] <= meas[p].volt_mv;
					i1_ff[p] <= meas[p].cur_dua;
				end
			end
		end
	end

	// outputs lag the state by one edge so the gate and probe pins come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_on <= '0;
			probe_output <= {4{ppst_pkg::PROBE_OFF}};
			for (int p = 0; p < ppst_pkg::NPORT; p++) begin
				cur_ff[p] <= '0;
			end
		end else if (ce) begin
			for (int p = 0; p < ppst_pkg::NPORT; p++) begin
				gate_on[p] <= (st_ff[p] == ppst_pkg::ST_START) || (st_ff[p] == ppst_pkg::ST_ON);
				case (st_ff[p])
					ppst_pkg::ST_PH1: probe_output[p] <= ppst_pkg::PROBE_4V;
					ppst_pkg::ST_PH2: probe_output[p] <= ppst_pkg::PROBE_9V;
					ppst_pkg::ST_CLASS: probe_output[p] <= ppst_pkg::PROBE_CLASS;
					default: probe_output[p] <= ppst_pkg::PROBE_OFF;
				endcase
				cur_ff[p] <= (meas[p].sense_mv > ppst_pkg::ADC_FULL) ? 9'h1FF
					: meas[p].sense_mv[8:0];
			end
		end
	end

	// ****************************************
	// faults and interrupt pin
	// ****************************************
	logic [8:0] fault_ff;
	logic [8:0] w1c;

	assign w1c = (wr && paddr == ppst_pkg::ADDR_FAULT) ? pwdata[8:0] : 9'h000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_ff <= '0;
		end else if (ce) begin
			// a new event in the clearing cycle survives the clear
			fault_ff <= clr ? 9'h000
				: ((fault_ff & ~w1c) | {wd_evt_ff, dis_evt_ff, oc_evt_ff});
		end
	end
	assign int_o = 1'b0;
	assign int_oe = |fault_ff;

	// ****************************************
	// apb slave
	// ****************************************
	logic [31:0] rd_data;
	logic hit;

	assign pready = ce;
	assign wr = psel & penable & pwrite & ce & hit;
	assign setup = psel & ~penable & ce;
	assign pslverr = psel & penable & ~hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_rst_ff <= 1'b0;
		end else if (ce) begin
			soft_rst_ff <= wr && paddr == ppst_pkg::ADDR_GRST && pwdata[ppst_pkg::GRST_SOFT_BIT];
		end
	end

	always_comb begin
		hit = 1'b1;
		rd_data = 32'h0000_0000;
		case (paddr)
			ppst_pkg::ADDR_CTRL: rd_data = {16'h0000, ctrl_ff};
			ppst_pkg::ADDR_DISC: rd_data = {23'h000000, disc_ff};
			ppst_pkg::ADDR_ACTH: rd_data = {29'h00000000, acth_ff};
			ppst_pkg::ADDR_STAT: rd_data = {10'h000, det_ff[3], det_ff[2], det_ff[1], det_ff[0],
				gate_on, ready_ff, auto_ff, address_latched};
			ppst_pkg::ADDR_FAULT: rd_data = {23'h000000, fault_ff};
			ppst_pkg::ADDR_CUR_LO: rd_data = {7'h00, cur_ff[1], 7'h00, cur_ff[0]};
			ppst_pkg::ADDR_CUR_HI: rd_data = {7'h00, cur_ff[3], 7'h00, cur_ff[2]};
			ppst_pkg::ADDR_WDOG: rd_data = {24'h000000, wd_ff};
			ppst_pkg::ADDR_GRST: rd_data = 32'h0000_0000;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup) begin
			prdata <= rd_data;
		end
	end
endmodule

// *** tb/ppst_top_properties.sv ***
// Purpose: timing checks on the port sequencer pins
// Assumes: port 0 carries the traffic; TICK_CYC cycles make one ms
// Notes: long waits are bounded by counters, not by repetition
module ppst_top_properties #(
	parameter int TICK_CYC = 20,
	parameter int RSTPIN_CYC = 8
) (
	input logic pclk,
	input logic presetn,
	input logic reset_pin_n,
	input logic uvlo_ok,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic pready,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	input logic [3:0] overcurrent,
	input logic [3:0] gate_on,
	input ppst_pkg::ppst_probe_t [3:0] probe_output,
	input logic int_o,
	input logic int_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// run-length counters
	// ****************************************
	int cls_ff;
	int det_ff;
	int oc_ff;
	int pin_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cls_ff <= 0;
			det_ff <= 0;
			oc_ff <= 0;
			pin_ff <= 0;
		end else begin
			cls_ff <= (probe_output[0] == ppst_pkg::PROBE_CLASS) ? cls_ff + 1 : 0;
			det_ff <= (probe_output[0] inside {ppst_pkg::PROBE_4V, ppst_pkg::PROBE_9V}) ?
				det_ff + 1 : 0;
			oc_ff <= (overcurrent[0] && gate_on[0]) ? oc_ff + 1 : 0;
			pin_ff <= reset_pin_n ? 0 : pin_ff + 1;
		end
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_int_clear: assert property ((psel && penable && pwrite && pready &&
		paddr == ppst_pkg::ADDR_FAULT && pwdata[8:0] == 9'h1FF && gate_on == 4'h0)
		|=> !int_oe && !int_o)
		else $error("interrupt held after fault clear");
	chk_uvlo_gate_off: assert property ($fell(uvlo_ok) |-> ##[1:5] gate_on == 4'h0)
		else $error("gate stayed on under lockout");
	chk_phase_order: assert property ((probe_output[0] == ppst_pkg::PROBE_9V &&
		$past(probe_output[0]) != ppst_pkg::PROBE_9V) |-> $past(probe_output[0]) == ppst_pkg::PROBE_4V)
		else $error("second probe without first");
	chk_class_first: assert property ($rose(gate_on[0]) |->
		!($past(probe_output[0]) inside {ppst_pkg::PROBE_4V, ppst_pkg::PROBE_9V}))
		else $error("power straight from detection");
	chk_class_bound: assert property (cls_ff <= 23 * TICK_CYC)
		else $error("classification too long");
	chk_detect_bound: assert property (det_ff <= 330 * TICK_CYC)
		else $error("detection too long");
	chk_oc_bound: assert property (oc_ff <= 130 * TICK_CYC + 4)
		else $error("overcurrent tolerated too long");
	chk_oc_interrupt: assert property ($fell(gate_on[0]) && $past(overcurrent[0], 4) |->
		##[0:2] int_oe)
		else $error("no interrupt after overcurrent");
	chk_pin_reset_off: assert property (pin_ff == RSTPIN_CYC + 8 |->
		gate_on == 4'h0 && !int_oe)
		else $error("reset pin left state standing");
endmodule
bind ppst_top ppst_top_properties #(.TICK_CYC(TICK_CYC), .RSTPIN_CYC(RSTPIN_CYC)) u_chk (
	.pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n), .uvlo_ok(uvlo_ok),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
	.pwdata(pwdata),
	.overcurrent(overcurrent), .gate_on(gate_on), .probe_output(probe_output),
	.int_o(int_o), .int_oe(int_oe));

// *** tb/ppst_pd_model.sv ***
// Purpose: powered device loads on the four ports
// Assumes: 25 kohm signature when present, nothing otherwise
// Notes: sense level picks normal, light or full-scale load
module ppst_pd_model (
	input ppst_pkg::ppst_probe_t [3:0] probe_output,
	input logic [3:0] gate_on,
	input logic [3:0] present,
	input logic [3:0] light,
	input logic [3:0] big,
	input logic [3:0] oc,
	output ppst_pkg::ppst_meas_t [3:0] meas,
	output logic [3:0] overcurrent,
	output logic [3:0] near_rail,
	output logic [3:0] ac_below
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// load response
	// ****************************************
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			meas[i] = '0;
			if (probe_output[i] == ppst_pkg::PROBE_4V) begin
				meas[i].volt_mv = 14'h0FA0;
				meas[i].cur_dua = present[i] ? 16'h0640 : 16'h0000;
			end
			if (probe_output[i] == ppst_pkg::PROBE_9V) begin
				meas[i].volt_mv = 14'h2454;
				meas[i].cur_dua = present[i] ? 16'h0E88 : 16'h0000;
			end
			// a light load sits under the disconnect level
			if (gate_on[i]) begin
				meas[i].sense_mv = big[i] ? 10'h3FF : light[i] ? 10'h002 : 10'h064;
			end
		end
	end
	assign overcurrent = oc & gate_on;
	assign near_rail = 4'h0;
	assign ac_below = 4'h0;
endmodule

// *** tb/ppst_top_tb.sv ***
// Purpose: register and port sequence tests of the sequencer
// Assumes: 1 ms shortened to 20 cycles, reset pin minimum to 8
// Notes: port 0 carries every scenario
module ppst_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 20;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdv;
	logic pready, pslverr, err, int_o, int_oe;
	logic reset_pin_n = 1, auto_strap = 0, midspan_strap = 0, uvlo_ok = 1, osc_fail = 0;
	logic [3:0] address_straps = 4'hA, present = 4'h1, light = '0, big = '0, oc = '0;
	logic [3:0] ac_below, near_rail, overcurrent, gate_on, address_latched;
	logic [2:0] ac_threshold_sel;
	ppst_pkg::ppst_meas_t [3:0] meas;
	ppst_pkg::ppst_probe_t [3:0] probe_output;
	int failures = 0;
	int tests_run = 0;
	always #10 pclk = ~pclk;
	ppst_top #(.TICK_CYC(TK), .RSTPIN_CYC(8)) uut (.pclk, .presetn, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n, .address_straps,
		.auto_strap, .midspan_strap, .uvlo_ok, .osc_fail, .ac_below, .near_rail, .overcurrent,
		.meas, .gate_on, .probe_output, .ac_threshold_sel, .address_latched, .int_o, .int_oe);
	ppst_pd_model pd (.probe_output, .gate_on, .present, .light, .big, .oc, .meas,
		.overcurrent, .near_rail, .ac_below);
	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(rdv & m, e);
	endtask
	task automatic cg(input logic v);
		chk({31'h0, gate_on[0]}, {31'h0, v});
	endtask
	task automatic wait_gate(input logic v);
		int n;
		n = 0;
		while (gate_on[0] !== v && n < 30000) begin
			@(posedge pclk);
			n++;
		end
		cg(v);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		wt(16);
		presetn <= 1'b1;
		wt(4);
		rdc(ppst_pkg::ADDR_DISC, 32'h1FF, 32'h15E);
		rdc(ppst_pkg::ADDR_STAT, 32'hF, 32'hA);
		rdc(8'h40, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, err}, 32'h1);
		address_straps <= 4'h5;
		wt(10);
		chk({28'h0, address_latched}, 32'hA);
		apb(1'b1, ppst_pkg::ADDR_ACTH, 32'h5);
		wt(1);
		chk({29'h0, ac_threshold_sel}, 32'h5);
		apb(1'b1, ppst_pkg::ADDR_DISC, 32'hA);
		rdc(ppst_pkg::ADDR_DISC, 32'h1FF, 32'hA);
		apb(1'b1, ppst_pkg::ADDR_CTRL, 32'h11);
		wait_gate(1'b1);
		rdc(ppst_pkg::ADDR_STAT, 32'h1C00, 32'h400);
		wt(70 * TK);
		light <= 4'h1;
		wt(8 * TK);
		cg(1'b1);
		wt(4 * TK);
		cg(1'b0);
		light <= 4'h0;
		rdc(ppst_pkg::ADDR_FAULT, 32'h1FF, 32'h10);
		chk({31'h0, int_oe}, 32'h1);
		apb(1'b1, ppst_pkg::ADDR_FAULT, 32'h1FF);
		wt(2);
		chk({31'h0, int_oe}, 32'h0);
		apb(1'b1, ppst_pkg::ADDR_CTRL, 32'h1011);
		wait_gate(1'b1);
		wt(70 * TK);
		oc <= 4'h1;
		wt(55 * TK);
		cg(1'b1);
		wt(10 * TK);
		cg(1'b0);
		oc <= 4'h0;
		rdc(ppst_pkg::ADDR_FAULT, 32'h1FF, 32'h1);
		wt(880 * TK);
		cg(1'b0);
		wait_gate(1'b1);
		apb(1'b1, ppst_pkg::ADDR_FAULT, 32'h1);
		rdc(ppst_pkg::ADDR_CUR_LO, 32'h1FF, 32'h64);
		big <= 4'h1;
		wt(4);
		rdc(ppst_pkg::ADDR_CUR_LO, 32'h1FF, 32'h1FF);
		big <= 4'h0;
		uvlo_ok <= 1'b0;
		wt(6);
		cg(1'b0);
		uvlo_ok <= 1'b1;
		wt(TK);
		rdc(ppst_pkg::ADDR_STAT, 32'h20, 32'h0);
		wt(4 * TK);
		rdc(ppst_pkg::ADDR_STAT, 32'h20, 32'h20);
		osc_fail <= 1'b1;
		apb(1'b1, ppst_pkg::ADDR_CTRL, 32'h1111);
		wt(400 * TK);
		cg(1'b0);
		osc_fail <= 1'b0;
		wait_gate(1'b1);
		wt(70 * TK);
		osc_fail <= 1'b1;
		wt(6);
		cg(1'b0);
		osc_fail <= 1'b0;
		rdc(ppst_pkg::ADDR_FAULT, 32'h1FF, 32'h10);
		auto_strap <= 1'b1;
		apb(1'b1, ppst_pkg::ADDR_GRST, 32'h10);
		rdc(ppst_pkg::ADDR_DISC, 32'h1FF, 32'h15E);
		rdc(ppst_pkg::ADDR_STAT, 32'h1F, 32'h15);
		wait_gate(1'b1);
		midspan_strap <= 1'b1;
		auto_strap <= 1'b0;
		apb(1'b1, ppst_pkg::ADDR_DISC, 32'h14);
		reset_pin_n <= 1'b0;
		wt(40);
		reset_pin_n <= 1'b1;
		wt(10);
		cg(1'b0);
		rdc(ppst_pkg::ADDR_DISC, 32'h1FF, 32'h15E);
		rdc(ppst_pkg::ADDR_CTRL, 32'hFFFF, 32'h8000);
		present <= 4'h0;
		apb(1'b1, ppst_pkg::ADDR_CTRL, 32'h1);
		wt(250 * TK);
		rdc(ppst_pkg::ADDR_STAT, 32'h1C00, 32'hC00);
		finish_test();
	end
	initial begin
		wt(95000);
		failures++;
		finish_test();
	end
endmodule
